/* File: hdl/dbps_edge_if.sv */
/*
  Carrier for a synchronised outside clock and its detected edges.
  Assumes the producer and the consumer share one clock.
*/
`timescale 1ns/1ps

interface dbps_edge_if;
  logic level;
  logic rise;
  logic fall;
  modport src (output level, output rise, output fall);
  modport dst (input level, input rise, input fall);
endinterface : dbps_edge_if

/* File: hdl/dbps_edge_sync.sv */
/*
  Two-flop synchroniser and edge finder for a clock arriving from outside.
  Assumes the outside clock is much slower than clk_in (at least four samples per half period).
*/
`timescale 1ns/1ps

module dbps_edge_sync (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // Outside clock pin
  input wire logic pin_in,
  // Synchronised level and edges
  dbps_edge_if.src edge_if
);

  typedef struct packed {
    logic meta;
    logic sync;
    logic prev;
    logic [2:0] warm;
  } dbps_sync_t;

  dbps_sync_t q_r;
  dbps_sync_t q_nxt;

  // The first flop feeds only the second one
  always_comb begin
    q_nxt = q_r;
    q_nxt.meta = pin_in;
    q_nxt.sync = q_r.meta;
    q_nxt.prev = q_r.sync;
    q_nxt.warm = {q_r.warm[1:0], 1'b1};
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign edge_if.level = q_r.sync;
  // No edge until prev holds a real sample: a pin high through reset gives no false rise
  assign edge_if.rise = q_r.sync & ~q_r.prev & q_r.warm[2];
  assign edge_if.fall = ~q_r.sync & q_r.prev & q_r.warm[2];

endmodule : dbps_edge_sync

/* File: hdl/dbps_pin_mux.sv */
/*
  Pin sharing for receive channel 0: drop telecom bus data and alarm, or frame pulse,
  two general purpose outputs, serial line data and line clock.
  Assumes drop bytes and line bits are offered by logic on clk_in; the drop bus clock and the
  line clock arrive from outside and are sampled here. APB registers with zero wait states.
*/
// Behaviour
// RULE1: Shared pins carry drop bus functions when enabled, alternate functions otherwise.
// RULE2: Alarm goes high with each drop byte of an STS-1 carrying path AIS.
// RULE3: Alarm stays low for anything other than such a byte.
// RULE4: Frame pulse high one bit period with first frame bit when framer on.
// RULE5: Frame pulse stays inactive while the frame synchronizer is bypassed.
// RULE6: Every drop data bit updates on the rising drop bus clock edge.
// RULE7: Drop data bit 0 is the least significant bit, bit 7 the most.
// RULE8: First general purpose output follows line drive register bit 2.
// RULE9: Second general purpose output follows line drive register bit 3.
// RULE10: Bus disabled, DS3/E3/STS-1 data leaves as single-rail serial line data.
// RULE11: Line data changes on rising line clock edge by default.
// RULE12: DS3/E3 with clock invert bit set, line data changes on falling edge.
// RULE13: STS-1 operation always updates line data on the rising edge.
// RULE14: Bus disabled and framer disabled keeps the frame pulse low.
`timescale 1ns/1ps

module dbps_pin_mux
  import dbps_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [dbps_pkg::DBPS_AW-1:0] paddr_in,
  input wire logic [dbps_pkg::DBPS_DW-1:0] pwdata_in,
  output logic [dbps_pkg::DBPS_DW-1:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Internal drop byte source
  input wire logic [dbps_pkg::DBPS_BYTE_W-1:0] drop_byte_in,
  input wire logic drop_ais_in,
  // Internal serial line source
  input wire logic line_bit_in,
  input wire logic line_frame_start_in,
  output logic line_bit_take_out,
  // Outside clocks
  input wire logic drop_bus_clock_in,
  input wire logic line_clock_in,
  // Shared pins
  output logic [dbps_pkg::DBPS_BYTE_W-1:0] drop_data_bus_out,
  output logic drop_alarm_out,
  // Interrupt
  output logic irq_out
);

  typedef struct packed {
    logic [7:0] io_ctrl;
    logic [7:0] drive;
    logic [7:0] ctrl;
    logic [7:0] mask;
    logic [DBPS_EVT_W-1:0] status;
    logic [DBPS_DW-1:0] prdata;
    logic pready;
    logic pslverr;
    logic [DBPS_BYTE_W-1:0] drop_byte;
    logic alarm;
    logic line_bit;
    logic fp;
    logic line_clk;
    logic bit_take;
    logic [DBPS_BYTE_W-1:0] pin_bus;
    logic pin_alarm;
    logic irq;
  } dbps_state_t;

  dbps_state_t q_r;
  dbps_state_t q_nxt;

  dbps_edge_if drop_edge ();
  dbps_edge_if line_edge ();

  dbps_edge_sync u_drop_sync (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .pin_in(drop_bus_clock_in),
    .edge_if(drop_edge.src)
  );

  dbps_edge_sync u_line_sync (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .pin_in(line_clock_in),
    .edge_if(line_edge.src)
  );

  logic [13:0] idx;
  logic setup;
  logic wr_en;
  logic bus_en;
  logic fp_ok;
  logic inv_sel;
  logic upd;
  logic [DBPS_EVT_W-1:0] evt_set;
  logic [DBPS_EVT_W-1:0] evt_clr;
  logic mapped;
  logic bus_on;

  assign idx = paddr_in[15:2];
  assign setup = psel_in & ~penable_in;
  assign wr_en = psel_in & penable_in & q_r.pready & pwrite_in;
  assign mapped = idx inside {DBPS_IDX_IO_CTRL, DBPS_IDX_DRIVE, DBPS_IDX_CTRL, DBPS_IDX_STATUS, DBPS_IDX_MASK};
  assign bus_on = q_r.ctrl[DBPS_CTRL_BUS_EN_BIT];

  always_comb begin
    q_nxt = q_r;
    evt_set = '0;
    evt_clr = '0;

    // Register answer is prepared in the setup cycle, so the access phase needs no wait
    q_nxt.pready = setup;
    q_nxt.pslverr = 1'b0;
    q_nxt.prdata = '0;
    if (setup && !pwrite_in) begin
      case (idx)
        DBPS_IDX_IO_CTRL: q_nxt.prdata = {24'h000000, q_r.io_ctrl};
        DBPS_IDX_DRIVE: q_nxt.prdata = {24'h000000, q_r.drive};
        DBPS_IDX_CTRL: q_nxt.prdata = {24'h000000, q_r.ctrl};
        DBPS_IDX_STATUS: q_nxt.prdata = {30'h00000000, q_r.status};
        DBPS_IDX_MASK: q_nxt.prdata = {30'h00000000, q_r.mask[DBPS_EVT_W-1:0]};
        default: q_nxt.pslverr = 1'b1;
      endcase
    end else if (setup) begin
      case (idx)
        DBPS_IDX_IO_CTRL, DBPS_IDX_DRIVE, DBPS_IDX_CTRL, DBPS_IDX_STATUS, DBPS_IDX_MASK: q_nxt.pslverr = 1'b0;
        default: q_nxt.pslverr = 1'b1;
      endcase
    end

    if (wr_en) begin
      case (idx)
        DBPS_IDX_IO_CTRL: q_nxt.io_ctrl = pwdata_in[7:0];
        DBPS_IDX_DRIVE: q_nxt.drive = pwdata_in[7:0];
        DBPS_IDX_CTRL: q_nxt.ctrl = pwdata_in[7:0];
        DBPS_IDX_STATUS: evt_clr = pwdata_in[DBPS_EVT_W-1:0];
        DBPS_IDX_MASK: q_nxt.mask = {6'h00, pwdata_in[DBPS_EVT_W-1:0]};
        default: q_nxt.mask = q_r.mask;
      endcase
    end

    bus_en = q_nxt.ctrl[DBPS_CTRL_BUS_EN_BIT];
    // RULE5 RULE14 frame pulse gating
    fp_ok = ~bus_en & q_nxt.ctrl[DBPS_CTRL_FRM_EN_BIT] & ~q_nxt.ctrl[DBPS_CTRL_BYPASS_BIT];

    // RULE6 drop clock rise
    if (drop_edge.rise) begin
      q_nxt.drop_byte = bus_en ? drop_byte_in : '0;
      // RULE2 RULE3 alarm per byte
      q_nxt.alarm = bus_en & drop_ais_in;
      evt_set[DBPS_EVT_AIS_BIT] = bus_en & drop_ais_in;
    end
    if (!bus_en) begin
      q_nxt.alarm = 1'b0;
    end

    // RULE12 RULE13 falling edge only for DS3/E3 with invert set
    inv_sel = q_r.io_ctrl[DBPS_IO_CLK_INV_BIT] & ~q_r.ctrl[DBPS_CTRL_STS1_BIT];
    // RULE11 default rising edge
    upd = inv_sel ? line_edge.fall : line_edge.rise;
    q_nxt.bit_take = upd;
    q_nxt.line_clk = line_edge.level;
    // RULE10 serial line data
    if (upd) begin
      q_nxt.line_bit = line_bit_in;
      // RULE4 pulse holds for one bit period
      q_nxt.fp = fp_ok & line_frame_start_in;
      evt_set[DBPS_EVT_FRAME_BIT] = fp_ok & line_frame_start_in;
    end
    if (!fp_ok) begin
      q_nxt.fp = 1'b0;
    end

    // Set wins over a clear in the same cycle
    q_nxt.status = (q_r.status & ~evt_clr) | evt_set;
    q_nxt.irq = |(q_nxt.status & q_nxt.mask[DBPS_EVT_W-1:0]);

    // RULE1 RULE7 shared pin selection, bit 0 is the LSB
    if (bus_en) begin
      q_nxt.pin_bus = q_nxt.drop_byte;
      q_nxt.pin_alarm = q_nxt.alarm;
    end else begin
      q_nxt.pin_bus = '0;
      // RULE8 RULE9 general purpose outputs
      q_nxt.pin_bus[DBPS_PIN_GP_A] = q_nxt.drive[DBPS_DRV_GP_A_BIT];
      q_nxt.pin_bus[DBPS_PIN_GP_B] = q_nxt.drive[DBPS_DRV_GP_B_BIT];
      q_nxt.pin_bus[DBPS_PIN_LINE_DATA] = q_nxt.line_bit;
      q_nxt.pin_bus[DBPS_PIN_LINE_CLK] = q_nxt.line_clk;
      q_nxt.pin_alarm = q_nxt.fp;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      q_r <= '0;
      q_r.io_ctrl <= DBPS_RST_IO_CTRL;
      q_r.drive <= DBPS_RST_DRIVE;
      q_r.ctrl <= DBPS_RST_CTRL;
      q_r.mask <= DBPS_RST_MASK;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign prdata_out = q_r.prdata;
  assign pready_out = q_r.pready;
  assign pslverr_out = q_r.pslverr;
  assign line_bit_take_out = q_r.bit_take;
  assign drop_data_bus_out = q_r.pin_bus;
  assign drop_alarm_out = q_r.pin_alarm;
  assign irq_out = q_r.irq;

  default clocking dbps_cb @(posedge clk_in);
  endclocking
  default disable iff (!rstn_in);

  // RULE1 pin selection
  pin_select_a: assert property (q_r.pin_alarm == (q_r.ctrl[DBPS_CTRL_BUS_EN_BIT] ? q_r.alarm : q_r.fp)) // RULE1
    else $error("alarm pin does not match selected function");

  // RULE2 alarm on AIS byte
  ais_alarm_a: assert property ((drop_edge.rise && bus_en && drop_ais_in && !wr_en) |=> drop_alarm_out) // RULE2
    else $error("alarm missing for AIS byte");

  // RULE3 alarm low otherwise
  alarm_low_a: assert property ((drop_edge.rise && !drop_ais_in) |=> (!drop_alarm_out || !bus_on)) // RULE3
    else $error("alarm high without AIS byte");

  // RULE4 frame pulse with first bit
  frame_pulse_a: assert property ((upd && fp_ok && line_frame_start_in && !wr_en) |=> drop_alarm_out [*2]) // RULE4
    else $error("frame pulse missing at first bit");

  // RULE5 bypass silences pulse
  bypass_quiet_a: assert property (q_r.ctrl[DBPS_CTRL_BYPASS_BIT] |-> !q_r.fp) // RULE5
    else $error("frame pulse while bypassed");

  // RULE6 drop data only on rising edge
  drop_stable_a: assert property (!drop_edge.rise |=> $stable(q_r.drop_byte)) // RULE6
    else $error("drop byte changed without clock rise");

  // RULE8 first general purpose output
  gp_a_follow_a: assert property (!q_r.ctrl[DBPS_CTRL_BUS_EN_BIT] |-> drop_data_bus_out[DBPS_PIN_GP_A] == q_r.drive[2]) // RULE8
    else $error("first general purpose output wrong");

  // RULE9 second general purpose output
  gp_b_follow_a: assert property (!q_r.ctrl[DBPS_CTRL_BUS_EN_BIT] |-> drop_data_bus_out[DBPS_PIN_GP_B] == q_r.drive[3]) // RULE9
    else $error("second general purpose output wrong");

  // RULE13 no falling update for STS-1
  sts1_rise_a: assert property ((q_r.ctrl[DBPS_CTRL_STS1_BIT] && line_edge.fall) |=> !line_bit_take_out) // RULE13
    else $error("STS-1 line data updated on falling edge");

  // RULE12 invert moves update to falling edge
  inv_fall_a: assert property ((inv_sel && line_edge.rise) |=> !line_bit_take_out) // RULE12
    else $error("inverted clock update on rising edge");

  // RULE14 framer off keeps pulse low
  framer_off_a: assert property (!q_r.ctrl[DBPS_CTRL_FRM_EN_BIT] |-> !q_r.fp) // RULE14
    else $error("frame pulse while framer disabled");

  // APB zero wait answer
  apb_ready_a: assert property (pready_out == $past(setup))
    else $error("ready not one cycle after setup");

  // APB unmapped index refused
  apb_unmapped_a: assert property ((setup && !mapped) |=> pslverr_out)
    else $error("unmapped index without error");

  // APB mapped index accepted
  apb_mapped_a: assert property ((setup && mapped) |=> !pslverr_out)
    else $error("mapped index answered with error");

  // APB upper read bits zero
  rd_upper_zero_a: assert property (pready_out |-> prdata_out[31:8] == 24'h000000)
    else $error("read data upper bits not zero");

  // Control write lands
  wr_ctrl_a: assert property ((wr_en && idx == DBPS_IDX_CTRL) |=> q_r.ctrl == $past(pwdata_in[7:0]))
    else $error("control write lost");

  // RULE8 drive write lands
  wr_drive_a: assert property ((wr_en && idx == DBPS_IDX_DRIVE) |=> q_r.drive == $past(pwdata_in[7:0])) // RULE8
    else $error("drive write lost");

  // Event sets status
  status_set_a: assert property ((|evt_set) |=> (q_r.status & $past(evt_set)) == $past(evt_set))
    else $error("event did not set status");

  // Write one clears unless set
  status_clr_a: assert property ((wr_en && idx == DBPS_IDX_STATUS) |=>
    (q_r.status & $past(pwdata_in[DBPS_EVT_W-1:0] & ~evt_set)) == '0)
    else $error("status bit not cleared");

  // Interrupt level
  irq_level_a: assert property (irq_out == |(q_r.status & q_r.mask[DBPS_EVT_W-1:0]))
    else $error("interrupt level wrong");

  // RULE14 pin low framer off
  alarm_bus_off_a: assert property ((!bus_on && !q_r.ctrl[DBPS_CTRL_FRM_EN_BIT]) |-> !drop_alarm_out) // RULE14
    else $error("frame pulse pin high with framer off");

  // RULE5 pin quiet bypassed
  bypass_pin_a: assert property ((!bus_on && q_r.ctrl[DBPS_CTRL_BYPASS_BIT]) |-> !drop_alarm_out) // RULE5
    else $error("frame pulse pin high while bypassed");

  // RULE10 line data pin
  line_pin_a: assert property (!bus_on |-> drop_data_bus_out[DBPS_PIN_LINE_DATA] == q_r.line_bit) // RULE10
    else $error("line data pin wrong");

  // RULE1 line clock pin
  line_clk_pin_a: assert property (!bus_on |-> drop_data_bus_out[DBPS_PIN_LINE_CLK] == $past(line_edge.level)) // RULE1
    else $error("line clock pin wrong");

  // RULE1 unused pins low
  spare_zero_a: assert property (!bus_on |-> drop_data_bus_out[7:6] == 2'h0 && drop_data_bus_out[4:3] == 2'h0) // RULE1
    else $error("unused shared pin driven high");

  // RULE7 whole byte out
  drop_pins_a: assert property (bus_on |-> drop_data_bus_out == q_r.drop_byte) // RULE7
    else $error("drop bus pins differ from byte");

  // RULE11 data holds between updates
  line_hold_a: assert property (!upd |=> $stable(q_r.line_bit)) // RULE11
    else $error("line data changed without update edge");

  // RULE11 rising edge update
  rise_update_a: assert property ((!inv_sel && line_edge.rise) |=> line_bit_take_out) // RULE11
    else $error("no update on rising line clock");

  // RULE12 falling edge update
  fall_update_a: assert property ((inv_sel && line_edge.fall) |=> line_bit_take_out) // RULE12
    else $error("no update on falling line clock");

  // RULE4 pulse spans bit
  frame_hold_a: assert property ((!upd && fp_ok) |=> $stable(q_r.fp)) // RULE4
    else $error("frame pulse changed within a bit");

  // RULE2 alarm spans byte
  alarm_hold_a: assert property ((!drop_edge.rise && bus_en) |=> $stable(q_r.alarm)) // RULE2
    else $error("alarm changed within a byte");

  // RULE3 alarm cleared off bus
  alarm_off_a: assert property (!bus_on |-> !q_r.alarm) // RULE3
    else $error("alarm flag set with bus disabled");

endmodule : dbps_pin_mux

/* File: hdl/dbps_pkg.sv */
/*
  Constants shared by the drop bus channel 0 pin sharing block: register indices,
  field positions, reset values and bus widths.
  Assumes a 32-bit APB master whose byte address is four times the register index.
*/
package dbps_pkg;

  // Register indices; the byte address is four times the index
  localparam logic [13:0] DBPS_IDX_IO_CTRL = 14'h1F01;
  localparam logic [13:0] DBPS_IDX_DRIVE = 14'h1F80;
  localparam logic [13:0] DBPS_IDX_CTRL = 14'h1F00;
  localparam logic [13:0] DBPS_IDX_STATUS = 14'h1F02;
  localparam logic [13:0] DBPS_IDX_MASK = 14'h1F03;

  // Bus widths
  localparam int DBPS_AW = 16;
  localparam int DBPS_DW = 32;
  localparam int DBPS_BYTE_W = 8;
  localparam int DBPS_EVT_W = 2;

  // Field positions
  localparam int DBPS_IO_CLK_INV_BIT = 2;
  localparam int DBPS_DRV_GP_A_BIT = 2;
  localparam int DBPS_DRV_GP_B_BIT = 3;
  localparam int DBPS_CTRL_BUS_EN_BIT = 0;
  localparam int DBPS_CTRL_FRM_EN_BIT = 1;
  localparam int DBPS_CTRL_BYPASS_BIT = 2;
  localparam int DBPS_CTRL_STS1_BIT = 3;
  localparam int DBPS_EVT_FRAME_BIT = 0;
  localparam int DBPS_EVT_AIS_BIT = 1;

  // Shared pin positions on the drop data bus
  localparam int DBPS_PIN_GP_A = 0;
  localparam int DBPS_PIN_GP_B = 1;
  localparam int DBPS_PIN_LINE_DATA = 2;
  localparam int DBPS_PIN_LINE_CLK = 5;

  // Reset values
  localparam logic [7:0] DBPS_RST_IO_CTRL = 8'h00;
  localparam logic [7:0] DBPS_RST_DRIVE = 8'h00;
  localparam logic [7:0] DBPS_RST_CTRL = 8'h00;
  localparam logic [7:0] DBPS_RST_MASK = 8'h00;

endpackage : dbps_pkg

/* File: tb/dbps_liu_model.sv */
/*
  Line interface unit stand-in: makes the free running line clock.
  Assumes the bench watches the shared pins itself.
*/
`timescale 1ns/1ps

module dbps_liu_model (
  // Line clock towards the block
  output logic line_clock_out
);
  // Odd start offset keeps it unrelated in phase to clk_in
  initial begin
    line_clock_out = 1'b0;
    #3.3;
    forever #62.5 line_clock_out = ~line_clock_out;
  end
endmodule : dbps_liu_model

/* File: tb/testbench.sv */
/*
  Self-checking bench for the drop bus pin sharing block.
  Assumes zero wait state APB and outside clocks sampled by clk_in.
*/
`timescale 1ns/1ps

module testbench;
  import dbps_pkg::*;
  localparam logic [15:0] A_IO = {DBPS_IDX_IO_CTRL, 2'b00};
  localparam logic [15:0] A_DRV = {DBPS_IDX_DRIVE, 2'b00};
  localparam logic [15:0] A_CTRL = {DBPS_IDX_CTRL, 2'b00};
  localparam logic [15:0] A_ST = {DBPS_IDX_STATUS, 2'b00};
  localparam logic [15:0] A_MASK = {DBPS_IDX_MASK, 2'b00};
  logic clk_in, rstn_in, psel, penable, pwrite, rdy, err, dbit, dfs, take, dclk, lclk, ais, alarm, irq;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [7:0] dbyte, pins;
  int n_fail, comparisons;

  dbps_liu_model liu (.line_clock_out(lclk));

  dbps_pin_mux DUT (.clk_in(clk_in), .rstn_in(rstn_in), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(rdy),
    .pslverr_out(err), .drop_byte_in(dbyte), .drop_ais_in(ais), .line_bit_in(dbit),
    .line_frame_start_in(dfs), .line_bit_take_out(take), .drop_bus_clock_in(dclk),
    .line_clock_in(lclk), .drop_data_bus_out(pins), .drop_alarm_out(alarm), .irq_out(irq));

  task summarize;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : summarize

  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t %s", $time, m);
    end
  endtask : chk

  task apb(input logic w, input logic [15:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
    int n;
    @(posedge clk_in);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    n = 0;
    // Request stands until ready is seen at a rising edge; only the watchdog ends a hang
    do begin
      @(posedge clk_in);
      n++;
    end while (rdy !== 1'b1);
    chk(32'(n), 32'h1, "apb zero wait");
    r = prdata;
    e = err;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wr(input logic [15:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
    repeat (2) @(negedge clk_in);
  endtask : wr

  task rd(input logic [15:0] a, input logic [31:0] exp, input logic eerr, input string m);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, exp, m);
    chk(32'(e), 32'(eerr), m);
  endtask : rd

  task wait_take;
    int n;
    n = 0;
    do begin
      @(negedge clk_in);
      n++;
    end while (take !== 1'b1 && n < 100);
    chk(32'(take), 32'h1, "take pulse");
  endtask : wait_take

  task line_run(input logic [7:0] c, input logic [7:0] io, input logic fp, input logic lvl);
    wr(A_CTRL, {24'h0, c});
    wr(A_IO, {24'h0, io});
    @(posedge clk_in);
    dbit <= 1'b1;
    dfs <= 1'b1;
    wait_take;
    wait_take;
    chk(32'(pins[2]), 32'h1, "line bit one");
    chk(32'(alarm), 32'(fp), "frame pulse");
    @(negedge clk_in);
    chk(32'(pins[5]), 32'(lvl), "update edge");
    @(posedge clk_in);
    dbit <= 1'b0;
    dfs <= 1'b0;
    wait_take;
    chk(32'(pins[2]), 32'h0, "line bit zero");
    chk(32'(alarm), 32'h0, "pulse one bit");
  endtask : line_run

  task dstep(input logic [7:0] b, input logic a);
    @(posedge clk_in);
    dclk <= 1'b0;
    dbyte <= b;
    ais <= a;
    repeat (5) @(posedge clk_in);
    dclk <= 1'b1;
    repeat (6) @(negedge clk_in);
  endtask : dstep

  task t_regs;
    rd(A_IO, 32'h0, 1'b0, "io reset");
    rd(A_CTRL, 32'h0, 1'b0, "ctrl reset");
    rd(A_MASK, 32'h0, 1'b0, "mask reset");
    rd(16'h0000, 32'h0, 1'b1, "unmapped");
    wr(A_DRV, 32'h4);
    chk(32'(pins[1:0]), 32'h1, "gp a");
    wr(A_DRV, 32'h8);
    chk(32'(pins[1:0]), 32'h2, "gp b");
    wr(A_DRV, 32'hC);
    rd(A_DRV, 32'hC, 1'b0, "drive readback");
    $display("register test done");
  endtask : t_regs

  task t_line;
    line_run(8'h02, 8'h00, 1'b1, 1'b1);
    line_run(8'h02, 8'h04, 1'b1, 1'b0);
    line_run(8'h0A, 8'h04, 1'b1, 1'b1);
    line_run(8'h06, 8'h00, 1'b0, 1'b1);
    line_run(8'h00, 8'h00, 1'b0, 1'b1);
    $display("line test done");
  endtask : t_line

  task t_drop;
    wr(A_CTRL, 32'h1);
    wr(A_ST, 32'h3);
    dstep(8'hB4, 1'b1);
    chk(32'(pins), 32'hB4, "drop byte");
    chk(32'(alarm), 32'h1, "ais alarm");
    @(posedge clk_in);
    dbyte <= 8'h1E;
    ais <= 1'b0;
    repeat (5) @(negedge clk_in);
    chk(32'(pins), 32'hB4, "held till rise");
    dstep(8'h1E, 1'b0);
    chk(32'(pins), 32'h1E, "bit order");
    chk(32'(alarm), 32'h0, "alarm low");
    rd(A_ST, 32'h2, 1'b0, "status");
    wr(A_MASK, 32'h2);
    chk(32'(irq), 32'h1, "irq on");
    wr(A_MASK, 32'h1);
    chk(32'(irq), 32'h0, "irq masked");
    wr(A_MASK, 32'h2);
    wr(A_ST, 32'h2);
    chk(32'(irq), 32'h0, "irq cleared");
    $display("drop bus test done");
  endtask : t_drop

  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  initial begin
    #200000;
    n_fail++;
    summarize;
  end

  initial begin
    {rstn_in, psel, penable, pwrite, dbit, dfs, dclk, ais} = '0;
    paddr = '0;
    pwdata = '0;
    dbyte = '0;
    repeat (8) @(posedge clk_in);
    rstn_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    t_regs;
    t_line;
    t_drop;
    summarize;
  end
endmodule : testbench
